/* include/clk_ctrl_defines.svh */
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH
`define OFS_LOCK_COUNT 12'h000
`define OFS_PLL_CONFIG 12'h004
`define OFS_USB_PLL_CONFIG 12'h008
`define OFS_CLK_GATE 12'h00C
`define OFS_SLOW_CLOCK 12'h010
`define OFS_CLOCK_DIVIDER 12'h014
`define OFS_POWER_MODE 12'h018
`define OFS_STATUS 12'h01C
`define RST_LOCK_COUNT 24'hFFFFFF
`define RST_PLL_CONFIG 20'h5C080
`define RST_USB_PLL_CONFIG 20'h28080
`define RST_CLK_GATE 16'hFFFF
`define M_OFF_ADD 9'h008
`define P_OFF_ADD 7'h02
`define SLOW_USB_OFF_BIT 5
`define SLOW_MPLL_OFF_BIT 5
`define LOCK_TIME_US 150
`define REF_CLOCK_MHZ 10
`define LOCK_CYCLES ((`LOCK_TIME_US * `REF_CLOCK_MHZ))
`endif

/* include/clk_ctrl_pkg.sv */
// Types shared by the clock control block
package clk_ctrl_pkg;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_IDLE, MODE_SLOW, MODE_POWER_OFF} power_mode_type;
    typedef struct packed
    {
        logic core_en;
        logic core_from_pll;
        logic bus_en;
        logic periph_en;
        logic [1:0] bus_div;
        logic [1:0] periph_div;
        logic cpu_on_bus;
    } core_gate_type;
    typedef struct packed
    {
        logic usb_en;
        logic usb_from_pll;
        logic usb_pll_on;
    } usb_gate_type;
endpackage

/* hdl/pll_clock_divider_control.sv */
// Clock source, lock gating, divider and power mode control behind an APB slave
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "clk_ctrl_defines.svh"
module pll_clock_divider_control
(
    input wire logic pclk, // Bus clock, also the reference count clock
    input wire logic presetn, // Asynchronous active-low reset
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic fast_bus_mode, // Processor is in fast bus mode
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    output clk_ctrl_pkg::core_gate_type core_gate, // Core, bus and peripheral clock controls
    output clk_ctrl_pkg::usb_gate_type usb_gate, // USB clock controls
    output logic [8:0] pll_m_mult, // Effective main PLL multiplier m
    output logic [6:0] pll_p_div, // Effective main PLL divider p
    output logic [1:0] pll_s_shift, // Main PLL post-divider exponent s
    output logic [15:0] periph_clk_en, // Per-peripheral clock enables
    output logic rtc_clk_en, // RTC clock enable
    output logic power_off_req // Request to remove internal power
);
    import clk_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [23:0] lock_count_q;
    logic [19:0] pll_cfg_q;
    logic [19:0] usb_cfg_q;
    logic [15:0] clk_gate_q;
    logic [5:0] slow_q;
    logic [2:0] div_wr_q;
    logic [2:0] div_act_q;
    logic div_pend_q;
    logic [1:0] div_wait_q;
    logic pll_written_q;
    logic usb_written_q;
    logic [23:0] lock_cnt_q;
    logic [23:0] usb_lock_cnt_q;
    power_mode_type mode_q;
    power_mode_type mode_d;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic lock_busy;
    logic usb_lock_busy;
    logic usb_pll_on;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0;
    assign lock_busy = lock_cnt_q != 24'h000000;
    assign usb_lock_busy = usb_lock_cnt_q != 24'h000000;
    assign usb_pll_on = !slow_q[`SLOW_USB_OFF_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Software registers; APB answers in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_count_q <= `RST_LOCK_COUNT;
            pll_cfg_q <= `RST_PLL_CONFIG;
            usb_cfg_q <= `RST_USB_PLL_CONFIG;
            clk_gate_q <= `RST_CLK_GATE;
            slow_q <= 6'h00;
            div_wr_q <= 3'h0;
        end
        else if (wr_en)
        begin
            if (hit(paddr, `OFS_LOCK_COUNT))
                lock_count_q <= pwdata[23:0];
            if (hit(paddr, `OFS_PLL_CONFIG))
                pll_cfg_q <= pwdata[19:0];
            if (hit(paddr, `OFS_USB_PLL_CONFIG))
                usb_cfg_q <= pwdata[19:0];
            if (hit(paddr, `OFS_CLK_GATE))
                clk_gate_q <= pwdata[15:0];
            if (hit(paddr, `OFS_SLOW_CLOCK))
                slow_q <= pwdata[5:0];
            if (hit(paddr, `OFS_CLOCK_DIVIDER))
                div_wr_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    `OFS_LOCK_COUNT: prdata <= {8'h00, lock_count_q};
                    `OFS_PLL_CONFIG: prdata <= {12'h000, pll_cfg_q};
                    `OFS_USB_PLL_CONFIG: prdata <= {12'h000, usb_cfg_q};
                    `OFS_CLK_GATE: prdata <= {16'h0000, clk_gate_q};
                    `OFS_SLOW_CLOCK: prdata <= {26'h0000000, slow_q};
                    `OFS_CLOCK_DIVIDER: prdata <= {29'h00000000, div_wr_q};
                    `OFS_POWER_MODE: prdata <= {30'h00000000, mode_q};
                    `OFS_STATUS: prdata <= {26'h0000000, div_act_q, usb_lock_busy,
                        lock_busy, pll_written_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main PLL lock counter, counted on the reference clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_cnt_q <= 24'h000000;
            pll_written_q <= 1'b0;
        end
        else if (wr_en && hit(paddr, `OFS_PLL_CONFIG))
        begin
            lock_cnt_q <= lock_count_q;
            pll_written_q <= 1'b1;
        end
        else if (lock_busy)
            lock_cnt_q <= lock_cnt_q - 24'h000001;
    end

    // USB PLL lock counter, restarted by each USB PLL config write only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            usb_lock_cnt_q <= 24'h000000;
            usb_written_q <= 1'b0;
        end
        else if (wr_en && hit(paddr, `OFS_USB_PLL_CONFIG))
        begin
            usb_lock_cnt_q <= lock_count_q;
            usb_written_q <= 1'b1;
        end
        else if (usb_lock_busy)
            usb_lock_cnt_q <= usb_lock_cnt_q - 24'h000001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider activation: deferred to lock end unless the power mode changes, else 2 cycles or 1 from 1:1:1
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_act_q <= 3'h0;
            div_pend_q <= 1'b0;
            div_wait_q <= 2'h0;
        end
        else if (wr_en && hit(paddr, `OFS_CLOCK_DIVIDER))
        begin
            div_pend_q <= 1'b1;
            div_wait_q <= (div_act_q == 3'h0) ? 2'h1 : 2'h2;
        end
        else if (div_pend_q && !lock_busy)
        begin
            if (div_wait_q <= 2'h1)
            begin
                div_act_q <= div_wr_q;
                div_pend_q <= 1'b0;
                div_wait_q <= 2'h0;
            end
            else
                div_wait_q <= div_wait_q - 2'h1;
        end
        else if (mode_d != mode_q)
            div_act_q <= div_wr_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power mode machine; power-off leaves only through the wake-up reset
    always_comb
    begin
        mode_d = mode_q;
        if (wr_en && hit(paddr, `OFS_POWER_MODE))
        begin
            unique case (mode_q)
                MODE_NORMAL: mode_d = power_mode_type'(pwdata[1:0]);
                MODE_IDLE, MODE_SLOW:
                    if (pwdata[1:0] == 2'h0)
                        mode_d = MODE_NORMAL;
                MODE_POWER_OFF: mode_d = MODE_POWER_OFF;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= MODE_NORMAL;
        else
            mode_q <= mode_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock controls, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_gate <= '0;
            usb_gate <= '0;
            periph_clk_en <= 16'h0000;
            rtc_clk_en <= 1'b0;
            power_off_req <= 1'b0;
            pll_m_mult <= 9'h000;
            pll_p_div <= 7'h00;
            pll_s_shift <= 2'h0;
        end
        else
        begin
            core_gate.core_en <= !lock_busy && (mode_q == MODE_NORMAL
                || mode_q == MODE_SLOW);
            core_gate.core_from_pll <= pll_written_q && !lock_busy
                && mode_q != MODE_SLOW;
            core_gate.bus_en <= !lock_busy && mode_q != MODE_POWER_OFF;
            core_gate.periph_en <= !lock_busy && mode_q != MODE_POWER_OFF;
            core_gate.bus_div <= div_act_q[2] ? 2'h2 : {1'b0, div_act_q[1]};
            core_gate.periph_div <= div_act_q[2] ? 2'h2
                : 2'({1'b0, div_act_q[1]} + {1'b0, div_act_q[0]});
            core_gate.cpu_on_bus <= div_act_q[1] && fast_bus_mode;
            usb_gate.usb_pll_on <= usb_pll_on;
            usb_gate.usb_en <= !(usb_written_q && usb_lock_busy && usb_pll_on);
            usb_gate.usb_from_pll <= usb_written_q && usb_pll_on && !usb_lock_busy;
            periph_clk_en <= (mode_q == MODE_POWER_OFF) ? 16'h0000 : clk_gate_q;
            rtc_clk_en <= 1'b1;
            power_off_req <= mode_q == MODE_POWER_OFF;
            pll_m_mult <= 9'(pll_cfg_q[19:12]) + `M_OFF_ADD;
            pll_p_div <= 7'(pll_cfg_q[9:4]) + `P_OFF_ADD;
            pll_s_shift <= pll_cfg_q[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    lock_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_busy |=> !core_gate.core_en && !core_gate.bus_en)
        else $error("clocks not gated during lock");
    lock_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit(paddr, `OFS_PLL_CONFIG) && lock_count_q != 0 |=> lock_busy)
        else $error("lock not started by PLL write");
    source_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pll_written_q |=> !core_gate.core_from_pll)
        else $error("core on PLL before config write");
    switch_pll_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(lock_busy) && mode_q == MODE_NORMAL |=> core_gate.core_from_pll)
        else $error("core not on PLL after lock");
    usb_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        usb_written_q && usb_lock_busy && usb_pll_on |=> !usb_gate.usb_en)
        else $error("usb clock not low during lock");
    div_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_busy && !(mode_d != mode_q) |=> $stable(div_act_q))
        else $error("divider changed during lock");
    div_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit(paddr, `OFS_CLOCK_DIVIDER) && div_act_q == 3'h0 && !lock_busy
        && mode_d == mode_q |=> ##1 div_act_q == $past(div_wr_q))
        else $error("divider not applied after one period");
    mode_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q != MODE_NORMAL && mode_d != mode_q |-> mode_d == MODE_NORMAL
        && mode_q != MODE_POWER_OFF)
        else $error("illegal power mode move");
    rtc_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> rtc_clk_en)
        else $error("rtc clock stopped");
    cov_lock_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(lock_busy));
    cov_idle_c: cover property (@(posedge pclk) disable iff (!presetn) mode_q == MODE_IDLE);
    cov_div_c: cover property (@(posedge pclk) disable iff (!presetn) div_act_q == 3'h4);
endmodule // pll_clock_divider_control

/* bench/pll_clock_divider_control_test.sv */
// Self-checking testbench for the clock source, lock, divider and power mode control
`timescale 1ns/100ps
`include "clk_ctrl_defines.svh"
module pll_clock_divider_control_test;
    import clk_ctrl_pkg::*;
    localparam int LOCK = 16;
    logic pclk, presetn, psel, penable, pwrite, fast_bus_mode, pready, pslverr;
    logic rtc_clk_en, power_off_req, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    core_gate_type core_gate;
    usb_gate_type usb_gate;
    logic [8:0] pll_m_mult;
    logic [6:0] pll_p_div;
    logic [1:0] pll_s_shift;
    logic [15:0] periph_clk_en;
    logic [1:0] mode_wr [8] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h3, 2'h0};
    logic [1:0] mode_rd [8] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3};
    int n_fail, samples_checked;
    pll_clock_divider_control i_pll_clock_divider_control
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .fast_bus_mode(fast_bus_mode), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .core_gate(core_gate), .usb_gate(usb_gate),
        .pll_m_mult(pll_m_mult), .pll_p_div(pll_p_div), .pll_s_shift(pll_s_shift),
        .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en), .power_off_req(power_off_req)
    );
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Holds the request until pready is sampled high; only the watchdog ends a stuck wait
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1);
        chk("access cycles", 32'h1, n);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [3:0] exp_div(input logic [2:0] c);
        case (c)
            3'h1: return 4'h1;
            3'h2: return 4'h5;
            3'h3: return 4'h6;
            3'h4: return 4'hA;
            default: return 4'h0;
        endcase
    endfunction
    task automatic chk_div(input logic [2:0] c);
        chk("divider", exp_div(c), {core_gate.bus_div, core_gate.periph_div});
        chk("cpu_on_bus", c[1] & fast_bus_mode, core_gate.cpu_on_bus);
    endtask
    task automatic chk_pll(input logic [31:0] c);
        chk("pll_m_mult", {1'h0, c[19:12]} + 9'h008, pll_m_mult);
        chk("pll_p_div", {1'h0, c[9:4]} + 7'h02, pll_p_div);
        chk("pll_s_shift", c[1:0], pll_s_shift);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    // Whole run is well under 2000 cycles; the margin covers slow lock releases
    initial
    begin
        #(100 * 20000);
        n_fail++;
        give_verdict();
    end
    initial
    begin
        presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 12'h000; pwdata = 32'h0; fast_bus_mode = 1'h0;
        n_fail = 0; samples_checked = 0;
        void'($urandom(76));
        waitc(5);
        presetn <= 1'h1;
        waitc(2);
        chk("core_from_pll", 32'h0, core_gate.core_from_pll);
        chk("core_en", 32'h1, core_gate.core_en);
        chk_pll(`RST_PLL_CONFIG);
        chk_div(3'h0);
        chk("usb_gate", 32'h5, usb_gate);
        chk("rtc_clk_en", 32'h1, rtc_clk_en);
        apb(1'h0, `OFS_PLL_CONFIG, 32'h0);
        chk("pll config", `RST_PLL_CONFIG, rd);
        apb(1'h1, `OFS_LOCK_COUNT, LOCK);
        waitc(2);
        chk("core_from_pll", 32'h0, core_gate.core_from_pll);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            // M at least 128, P at most 15, S at most 1 keeps the core above 3x reference
            cfg = ($urandom() & 32'h0007F0F1) | 32'h00080000;
            apb(1'h1, `OFS_PLL_CONFIG, cfg);
            waitc(2);
            chk("core gating", 32'h0, {core_gate.core_en, core_gate.bus_en});
            chk("periph_en", 32'h0, core_gate.periph_en);
            waitc(LOCK + 6);
            chk("core released", 32'h3, core_gate[8:7]);
            chk_pll(cfg);
        end
        apb(1'h1, `OFS_PLL_CONFIG, cfg);
        apb(1'h1, `OFS_CLOCK_DIVIDER, 32'h3);
        waitc(2);
        chk_div(3'h0);
        waitc(LOCK + 6);
        chk_div(3'h3);
        $display("test pll lock done");
        for (int c = 1; c <= 4; c++)
        begin
            apb(1'h1, `OFS_CLOCK_DIVIDER, 32'h0);
            fast_bus_mode <= 1'($urandom());
            waitc(8);
            apb(1'h1, `OFS_CLOCK_DIVIDER, c);
            waitc(4);
            chk_div(3'(c));
            apb(1'h1, `OFS_CLOCK_DIVIDER, (c % 4) + 1);
            waitc(2);
            chk_div(3'(c));
            waitc(6);
            chk_div(3'((c % 4) + 1));
        end
        $display("test divider done");
        cfg = $urandom() & 32'h000FF3F3;
        apb(1'h1, `OFS_USB_PLL_CONFIG, cfg);
        waitc(2);
        chk("usb_en", 32'h0, usb_gate.usb_en);
        waitc(LOCK + 6);
        chk("usb_gate", 32'h7, usb_gate);
        apb(1'h1, `OFS_SLOW_CLOCK, 32'h1 << `SLOW_USB_OFF_BIT);
        waitc(4);
        chk("usb pll off", 32'h0, usb_gate[1:0]);
        apb(1'h1, `OFS_SLOW_CLOCK, 32'h0);
        waitc(LOCK + 6);
        chk("usb pll on", 32'h3, usb_gate[1:0]);
        $display("test usb clock done");
        cfg = $urandom() & 32'h0000FFFF;
        apb(1'h1, `OFS_CLK_GATE, cfg);
        waitc(3);
        chk("periph_clk_en", cfg, periph_clk_en);
        chk("core and bus", 32'h3, {core_gate.core_en, core_gate.bus_en});
        apb(1'h0, 12'h020, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped read err", 32'h1, err);
        apb(1'h1, 12'h024, 32'hFFFF);
        chk("unmapped write", 32'h1, err);
        $display("test gating and bus done");
        for (int i = 0; i < 8; i++)
        begin
            apb(1'h1, `OFS_POWER_MODE, mode_wr[i]);
            waitc(3);
            chk("rtc_clk_en", 32'h1, rtc_clk_en);
            if (mode_rd[i] == 2'h1)
                chk("idle gating", 32'h1, {core_gate.core_en, core_gate.bus_en});
            if (mode_rd[i] == 2'h3)
                chk("power_off_req", 32'h1, power_off_req);
            apb(1'h0, `OFS_POWER_MODE, 32'h0);
            chk("power mode", mode_rd[i], rd[1:0]);
        end
        $display("test power modes done");
        give_verdict();
    end
endmodule // pll_clock_divider_control_test
